// File: verilog/pmc_mode_ctrl.sv
// Operating-mode and system-clock controller with an APB register slave.
//
// Operation
// RULE1: Reset clears the clock mode register, selecting the main clock.
// RULE2: After reset release the block runs in main active mode.
// RULE3: Main active mode uses only the main oscillator as clock source.
// RULE4: Sub active mode clocks CPU and peripherals from the sub oscillator.
// RULE5: Execution continues while the clock source is switched.
// RULE6: Low bits written 2 select the sub clock, main oscillator running.
// RULE7: Low bits written 3 on the sub clock stop the main oscillator.
// RULE8: Writing 2 restarts main; sub clock stays until zero is written.
// RULE9: Writing zero after main is stable moves back to the main clock.
// RULE10: Reset during sub active resets at once; then main active mode.
// RULE11: Setting bit 0 of sleep_control stops the CPU clock: SLEEP.
// RULE12: SLEEP stops only the CPU clock; oscillators and peripherals run.
// RULE13: SLEEP ends on reset or any enabled interrupt.
// RULE14: STOP halts main oscillator, system and peripheral clock; sub runs.
// RULE15: STOP holds RAM, control registers and port pin drive.
// RULE16: STOP ends only on reset or the five listed wake sources.
// RULE17: STOP released by reset resumes in main active mode.
// RULE18: STOP halts interval timer, and timers unless in event count mode.
// RULE19: STOP freezes all operation while keeping internal state.
// RULE20: Bit 1 selects the source; bit 0 stops main when sub is selected.
// RULE21: Bits 3 and 2 select the CPU clock division ratio.
// RULE22: Source switching never produces a truncated clock pulse.
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl (
  // Clock, reset and clock enable.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Oscillator pins, sampled as levels.
  input  wire logic                  main_osc_pin,
  input  wire logic                  sub_osc_pin,
  // CPU and interrupt side.
  input  wire logic                  stop_req,
  input  wire logic                  irq_any,
  input  wire pmc_pkg::pmc_wake_type wake,
  input  wire logic                  event_counter_mode,
  // Clock and power controls.
  output logic                       main_osc_en_q,
  output logic                       sub_osc_en_q,
  output pmc_pkg::pmc_gate_type      gate_q,
  output logic      [1:0]            cpu_div_sel_q,
  output logic                       hold_state_q,
  output logic                       bit_halt_q,
  output logic                       tc_halt_q,
  output pmc_pkg::pmc_mode_type      mode_out_q
);

  logic                  main_tick;
  logic                  sub_tick;
  logic [3:0]            cms_q;
  logic [7:0]            slp_q;
  pmc_pkg::pmc_mode_type mode_q;
  pmc_pkg::pmc_mode_type mode_d;
  pmc_pkg::pmc_mode_type active_mode;
  pmc_pkg::pmc_src_type  src_q;
  logic                  sys_tick;
  logic                  on_sub;
  logic                  mapped;
  logic                  acc;
  logic                  commit_wr;
  logic                  wr_cms;
  logic                  wr_slp;
  logic                  sleep_wake;
  logic [31:0]           rd_mux;

  // ==========================================================================
  // Oscillator edge detection.
  pmc_tick_sync u_main_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .osc_pin (main_osc_pin),
    .rise_q  (main_tick)
  );

  pmc_tick_sync u_sub_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .osc_pin (sub_osc_pin),
    .rise_q  (sub_tick)
  );

  // ==========================================================================
  // APB decode. One wait state lets read data and pready come from flops.
  assign mapped = (paddr == pmc_pkg::ADDR_CLOCK_MODE) ||
                  (paddr == pmc_pkg::ADDR_SLEEP) ||
                  (paddr == pmc_pkg::ADDR_STATUS);
  assign acc       = psel && penable && !pready;
  assign commit_wr = psel && penable && pready && pwrite && mapped;
  assign wr_cms    = commit_wr && (paddr == pmc_pkg::ADDR_CLOCK_MODE);
  assign wr_slp    = commit_wr && (paddr == pmc_pkg::ADDR_SLEEP);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      pmc_pkg::ADDR_CLOCK_MODE: rd_mux[3:0] = cms_q;
      pmc_pkg::ADDR_SLEEP:      rd_mux[7:0] = slp_q;
      pmc_pkg::ADDR_STATUS: begin
        rd_mux[pmc_pkg::STS_MAIN_RUN_BIT] = main_osc_en_q;
        rd_mux[pmc_pkg::STS_SRC_LSB +: 2] = src_q;
        rd_mux[pmc_pkg::STS_MODE_LSB +: 2] = mode_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready <= acc;
      if (acc) begin
        pslverr <= !mapped;
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ==========================================================================
  // Clock mode register; only the low four bits are kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cms_q <= pmc_pkg::CMS_RESET; // RULE1 RULE10
    end else if (ce && wr_cms) begin
      cms_q <= pwdata[3:0]; // RULE6 RULE7 RULE8 RULE9
    end
  end

  // ==========================================================================
  // Sleep register. A new request written in the same cycle as a wake-up
  // wins over the hardware clear, so that request is never lost.
  assign sleep_wake = (mode_q == pmc_pkg::PMC_SLEEP) && irq_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_q <= pmc_pkg::SLP_RESET;
    end else if (ce) begin
      if (wr_slp) begin
        slp_q <= {7'h00, pwdata[pmc_pkg::SLP_ENTER_BIT]}; // RULE11
      end else if (sleep_wake) begin
        slp_q[pmc_pkg::SLP_ENTER_BIT] <= 1'b0; // RULE13
      end
    end
  end

  // ==========================================================================
  // Source switch. The old source is released only right after one of its
  // own pulses and the new one taken only at one of its pulses, so no pulse
  // is ever cut. The switch is frozen in STOP, where main does not run.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= pmc_pkg::PMC_ON_MAIN; // RULE2
    end else if (ce && mode_q != pmc_pkg::PMC_STOP) begin
      case (src_q)
        pmc_pkg::PMC_ON_MAIN: begin
          if (cms_q[pmc_pkg::CMS_SUB_SEL_BIT] && main_tick) begin
            src_q <= pmc_pkg::PMC_TO_SUB; // RULE6 RULE20 RULE22
          end
        end
        pmc_pkg::PMC_TO_SUB: begin
          if (sub_tick) begin
            src_q <= pmc_pkg::PMC_ON_SUB; // RULE22
          end
        end
        pmc_pkg::PMC_ON_SUB: begin
          if (!cms_q[pmc_pkg::CMS_SUB_SEL_BIT] && sub_tick) begin
            src_q <= pmc_pkg::PMC_TO_MAIN; // RULE8 RULE9
          end
        end
        pmc_pkg::PMC_TO_MAIN: begin
          if (main_tick) begin
            src_q <= pmc_pkg::PMC_ON_MAIN; // RULE9 RULE22
          end
        end
        default: src_q <= pmc_pkg::PMC_ON_MAIN;
      endcase
    end
  end

  // The system clock is paused while the switch waits for the new source's edge and one period more,
  // up to two periods of it; the CPU sees a late pulse, never a stall.
  assign sys_tick = (src_q == pmc_pkg::PMC_ON_MAIN && main_tick) ||
                    (src_q == pmc_pkg::PMC_ON_SUB && sub_tick); // RULE3 RULE4 RULE5
  assign on_sub   = (src_q == pmc_pkg::PMC_ON_SUB) ||
                    (src_q == pmc_pkg::PMC_TO_MAIN);
  assign active_mode = on_sub ? pmc_pkg::PMC_SUB_ACTIVE
                              : pmc_pkg::PMC_MAIN_ACTIVE;

  // ==========================================================================
  // Operating mode.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      pmc_pkg::PMC_MAIN_ACTIVE, pmc_pkg::PMC_SUB_ACTIVE: begin
        if (stop_req) begin
          mode_d = pmc_pkg::PMC_STOP; // RULE14
        end else if (slp_q[pmc_pkg::SLP_ENTER_BIT]) begin
          mode_d = pmc_pkg::PMC_SLEEP; // RULE11
        end else begin
          mode_d = active_mode;
        end
      end
      pmc_pkg::PMC_SLEEP: begin
        if (irq_any) begin
          mode_d = active_mode; // RULE13
        end
      end
      pmc_pkg::PMC_STOP: begin
        if (|wake) begin
          mode_d = active_mode; // RULE16
        end
      end
      default: mode_d = pmc_pkg::PMC_MAIN_ACTIVE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= pmc_pkg::PMC_MAIN_ACTIVE; // RULE2 RULE10 RULE17
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================================
  // Oscillator enables and clock gates.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_en_q <= 1'b1;
      sub_osc_en_q  <= 1'b1;
      gate_q        <= '0;
    end else if (ce) begin
      main_osc_en_q <= (cms_q[1:0] != pmc_pkg::CMS_STOP_MAIN) &&
                       (mode_q != pmc_pkg::PMC_STOP); // RULE7 RULE14 RULE20
      sub_osc_en_q  <= 1'b1; // RULE14
      gate_q.sys    <= sys_tick && (mode_q != pmc_pkg::PMC_STOP);
      gate_q.cpu    <= sys_tick && (mode_q != pmc_pkg::PMC_STOP) &&
                       (mode_q != pmc_pkg::PMC_SLEEP); // RULE11 RULE12
      gate_q.peri   <= sys_tick && (mode_q != pmc_pkg::PMC_STOP); // RULE12 RULE14
    end
  end

  // ==========================================================================
  // Retention and peripheral halts during STOP; divider select and mode output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_state_q  <= 1'b0;
      bit_halt_q    <= 1'b0;
      tc_halt_q     <= 1'b0;
      cpu_div_sel_q <= 2'h0;
      mode_out_q    <= pmc_pkg::PMC_MAIN_ACTIVE;
    end else if (ce) begin
      hold_state_q  <= (mode_q == pmc_pkg::PMC_STOP); // RULE15 RULE19
      bit_halt_q    <= (mode_q == pmc_pkg::PMC_STOP); // RULE18
      tc_halt_q     <= (mode_q == pmc_pkg::PMC_STOP) &&
                       !event_counter_mode; // RULE18
      cpu_div_sel_q <= cms_q[pmc_pkg::CMS_DIV_LSB +: 2]; // RULE21
      mode_out_q    <= mode_q;
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_reset_main;
    !$past(presetn) |-> (cms_q == pmc_pkg::CMS_RESET) &&
                        (mode_q == pmc_pkg::PMC_MAIN_ACTIVE);
  endproperty
  a_reset_main: assert property (p_reset_main) // RULE1
    else $error("Mode or clock mode register wrong after reset.");

  property p_main_stop;
    ce && cms_q[1:0] == pmc_pkg::CMS_STOP_MAIN |=> !main_osc_en_q;
  endproperty
  a_main_stop: assert property (p_main_stop) // RULE7
    else $error("Main oscillator still enabled with low bits at three.");

  property p_stop_gates;
    ce && mode_q == pmc_pkg::PMC_STOP |=>
      !main_osc_en_q && !gate_q.peri && !gate_q.cpu && sub_osc_en_q;
  endproperty
  a_stop_gates: assert property (p_stop_gates) // RULE14
    else $error("Clock still running in STOP.");

  property p_sleep_cpu;
    ce && mode_q == pmc_pkg::PMC_SLEEP && sys_tick |=>
      gate_q.peri && !gate_q.cpu;
  endproperty
  a_sleep_cpu: assert property (p_sleep_cpu) // RULE12
    else $error("SLEEP gating of CPU or peripheral clock wrong.");

  property p_stop_hold;
    ce && mode_q == pmc_pkg::PMC_STOP && wake == '0 |=>
      mode_q == pmc_pkg::PMC_STOP && $stable(cms_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) // RULE16
    else $error("STOP left without a wake source.");

  property p_sleep_enter;
    ce && slp_q[0] && !stop_req && !irq_any &&
    (mode_q == pmc_pkg::PMC_MAIN_ACTIVE ||
     mode_q == pmc_pkg::PMC_SUB_ACTIVE) |=> mode_q == pmc_pkg::PMC_SLEEP;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) // RULE11
    else $error("Sleep bit set but SLEEP not entered.");

  property p_sleep_exit;
    ce && mode_q == pmc_pkg::PMC_SLEEP && irq_any |=>
      mode_q != pmc_pkg::PMC_SLEEP;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) // RULE13
    else $error("Interrupt did not end SLEEP.");

  property p_stay_sub;
    ce && src_q == pmc_pkg::PMC_ON_SUB && cms_q[1] &&
    mode_q != pmc_pkg::PMC_STOP |=> src_q == pmc_pkg::PMC_ON_SUB;
  endproperty
  a_stay_sub: assert property (p_stay_sub) // RULE8
    else $error("Left the sub clock while it is still selected.");

  property p_no_cut;
    ce && (src_q == pmc_pkg::PMC_TO_SUB || src_q == pmc_pkg::PMC_TO_MAIN)
      |=> !gate_q.sys;
  endproperty
  a_no_cut: assert property (p_no_cut) // RULE22
    else $error("Clock pulse passed during a source switch.");

  property p_stop_halts;
    ce && mode_q == pmc_pkg::PMC_STOP |=>
      bit_halt_q && hold_state_q && (tc_halt_q == !$past(event_counter_mode));
  endproperty
  a_stop_halts: assert property (p_stop_halts) // RULE18
    else $error("Timer halts wrong in STOP.");

endmodule // pmc_mode_ctrl
`default_nettype wire

// File: verilog/pmc_pkg.sv
// Package with the register map, field positions and types of the mode controller.
package pmc_pkg;

  // ==========================================================================
  // Register map: the printed offsets are word indices; bytes are four each.
  localparam int          ADDR_W         = 12;
  localparam logic [9:0]  IDX_CLOCK_MODE = 10'h0DD;
  localparam logic [9:0]  IDX_SLEEP      = 10'h0DE;
  localparam logic [9:0]  IDX_STATUS     = 10'h0DF;
  localparam logic [11:0] ADDR_CLOCK_MODE = {IDX_CLOCK_MODE, 2'h0};
  localparam logic [11:0] ADDR_SLEEP      = {IDX_SLEEP, 2'h0};
  localparam logic [11:0] ADDR_STATUS     = {IDX_STATUS, 2'h0};

  // ==========================================================================
  // Field positions and reset values.
  localparam int         CMS_MAIN_STOP_BIT = 0;
  localparam int         CMS_SUB_SEL_BIT   = 1;
  localparam int         CMS_DIV_LSB       = 2;
  localparam int         CMS_W             = 4;
  localparam int         SLP_ENTER_BIT     = 0;
  localparam logic [3:0] CMS_RESET         = 4'h0;
  localparam logic [7:0] SLP_RESET         = 8'h00;
  localparam int         STS_MAIN_RUN_BIT  = 0;
  localparam int         STS_SRC_LSB       = 1;
  localparam int         STS_MODE_LSB      = 3;
  localparam logic [1:0] CMS_STOP_MAIN     = 2'h3;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    PMC_MAIN_ACTIVE,
    PMC_SUB_ACTIVE,
    PMC_SLEEP,
    PMC_STOP
  } pmc_mode_type;

  typedef enum logic [1:0] {
    PMC_ON_MAIN,
    PMC_TO_SUB,
    PMC_ON_SUB,
    PMC_TO_MAIN
  } pmc_src_type;

  typedef struct packed {
    logic key_scan;
    logic watch_timer;
    logic event_counter_pin;
    logic serial_port;
    logic external;
  } pmc_wake_type;

  typedef struct packed {
    logic sys;
    logic cpu;
    logic peri;
  } pmc_gate_type;

endpackage

// File: verilog/pmc_tick_sync.sv
// Oscillator pin sampler that yields one pulse per rising oscillator edge.
`timescale 1ns/1ps
`default_nettype none
module pmc_tick_sync (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Raw oscillator level and rising-edge pulse.
  input  wire logic osc_pin,
  output logic      rise_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // ==========================================================================
  // Three-stage sampler; a level counts once the last two stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= osc_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
    end else if (ce) begin
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
      rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
    end
  end

endmodule // pmc_tick_sync
`default_nettype wire

// File: tb/pmc_mode_ctrl_test.sv
// Self-checking testbench of the operating-mode and clock controller.
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl_test;
  // ==========================================================================
  // Signals.
  logic                  pclk;
  logic                  presetn;
  logic                  ce;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  main_osc_pin;
  logic                  sub_osc_pin;
  logic                  stop_req;
  logic                  irq_any;
  pmc_pkg::pmc_wake_type wake;
  logic                  event_counter_mode;
  logic                  main_osc_en_q;
  logic                  sub_osc_en_q;
  pmc_pkg::pmc_gate_type gate_q;
  logic [1:0]            cpu_div_sel_q;
  logic                  hold_state_q;
  logic                  bit_halt_q;
  logic                  tc_halt_q;
  pmc_pkg::pmc_mode_type mode_out_q;
  logic [2:0]            cnt_m_q;
  logic [4:0]            cnt_s_q;
  logic [31:0]           rd;
  logic                  err;
  int                    n_mismatch;
  int                    comparisons;
  int                    ns;
  int                    nc;
  int                    np;

  pmc_mode_ctrl u_pmc_mode_ctrl (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_pin(main_osc_pin), .sub_osc_pin(sub_osc_pin),
    .stop_req(stop_req), .irq_any(irq_any), .wake(wake),
    .event_counter_mode(event_counter_mode),
    .main_osc_en_q(main_osc_en_q), .sub_osc_en_q(sub_osc_en_q),
    .gate_q(gate_q), .cpu_div_sel_q(cpu_div_sel_q),
    .hold_state_q(hold_state_q), .bit_halt_q(bit_halt_q),
    .tc_halt_q(tc_halt_q), .mode_out_q(mode_out_q)
  );

  // ==========================================================================
  // Clock and oscillators.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // The oscillators only swing while enabled, as a real crystal would.
  always @(posedge pclk) begin
    cnt_m_q <= cnt_m_q + 3'h1;
    cnt_s_q <= (cnt_s_q == 5'h13) ? 5'h00 : cnt_s_q + 5'h01;
    main_osc_pin <= main_osc_en_q & cnt_m_q[2];
    sub_osc_pin <= sub_osc_en_q & (cnt_s_q >= 5'h0A);
  end

  // ==========================================================================
  // Tasks.
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what,
               seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic wait_mode(input pmc_pkg::pmc_mode_type m);
    int i;
    for (i = 0; i < 60 && mode_out_q !== m; i++) @(posedge pclk);
    check(32'(mode_out_q), 32'(m), "mode");
    if (i >= 60) report_and_stop();
  endtask

  task automatic wait_src(input logic [1:0] s);
    int i;
    i = 0;
    do begin
      apb(1'b0, pmc_pkg::ADDR_STATUS, 32'h0);
      i++;
    end while (rd[2:1] !== s && i < 40);
    check(32'(rd[2:1]), 32'(s), "source state");
    if (i >= 40) report_and_stop();
  endtask

  task automatic count_pulses(input int ncyc);
    ns = 0;
    nc = 0;
    np = 0;
    repeat (ncyc) begin
      @(posedge pclk);
      ns += (gate_q.sys === 1'b1);
      nc += (gate_q.cpu === 1'b1);
      np += (gate_q.peri === 1'b1);
    end
  endtask

  task automatic pulse_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic enter_stop;
    @(posedge pclk);
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    wait_mode(pmc_pkg::PMC_STOP);
  endtask

  // ==========================================================================
  // Hang guard.
  initial begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    main_osc_pin = 1'b0;
    sub_osc_pin = 1'b0;
    stop_req = 1'b0;
    irq_any = 1'b0;
    wake = '0;
    event_counter_mode = 1'b0;
    cnt_m_q = 3'h0;
    cnt_s_q = 5'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(mode_out_q), 32'(pmc_pkg::PMC_MAIN_ACTIVE), "mode");
    check(32'(sub_osc_en_q), 32'h1, "sub osc on");
    apb(1'b0, pmc_pkg::ADDR_CLOCK_MODE, 32'h0);
    check(rd, 32'h0, "clock mode reset");
    apb(1'b0, pmc_pkg::ADDR_SLEEP, 32'h0);
    check(rd, 32'h0, "sleep reset");
    apb(1'b0, 12'h000, 32'h0);
    check(32'(err), 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    count_pulses(200);
    check(32'(ns >= 24 && ns <= 26), 32'h1, "main rate");
    // Switch to sub with divider 3; the CPU must keep running meanwhile.
    apb(1'b1, pmc_pkg::ADDR_CLOCK_MODE, 32'h0000_000E);
    count_pulses(100);
    check(32'(nc > 0), 32'h1, "cpu runs");
    check(32'(cpu_div_sel_q), 32'h3, "divider");
    wait_src(2'h2);
    check(32'(main_osc_en_q), 32'h1, "main on");
    wait_mode(pmc_pkg::PMC_SUB_ACTIVE);
    count_pulses(200);
    check(32'(ns >= 9 && ns <= 11), 32'h1, "sub rate");
    apb(1'b1, pmc_pkg::ADDR_CLOCK_MODE, 32'h0000_000F);
    apb(1'b0, pmc_pkg::ADDR_STATUS, 32'h0);
    check(32'(rd[0]), 32'h0, "main stopped");
    check(32'(main_osc_en_q), 32'h0, "main stopped");
    apb(1'b1, pmc_pkg::ADDR_CLOCK_MODE, 32'h0000_000E);
    repeat (100) @(posedge pclk);
    apb(1'b0, pmc_pkg::ADDR_STATUS, 32'h0);
    check(32'(rd[0]), 32'h1, "main restarted");
    check(32'(rd[2:1]), 32'h2, "still on sub");
    apb(1'b1, pmc_pkg::ADDR_CLOCK_MODE, 32'h0);
    wait_src(2'h0);
    wait_mode(pmc_pkg::PMC_MAIN_ACTIVE);
    count_pulses(200);
    check(32'(ns >= 24 && ns <= 26), 32'h1, "main again");
    // Reset while running on the sub clock.
    apb(1'b1, pmc_pkg::ADDR_CLOCK_MODE, 32'h0000_0002);
    wait_src(2'h2);
    pulse_reset();
    wait_mode(pmc_pkg::PMC_MAIN_ACTIVE);
    apb(1'b0, pmc_pkg::ADDR_CLOCK_MODE, 32'h0);
    check(rd, 32'h0, "clock mode after reset");
    // Sleep, then wake by an interrupt.
    apb(1'b1, pmc_pkg::ADDR_SLEEP, 32'h0000_0001);
    wait_mode(pmc_pkg::PMC_SLEEP);
    count_pulses(100);
    check(32'(nc), 32'h0, "cpu gated");
    check(32'(np > 0), 32'h1, "peri runs");
    check(32'(main_osc_en_q), 32'h1, "main runs");
    // With the clock enable low nothing moves, not even a pending wake-up.
    @(posedge pclk);
    ce <= 1'b0;
    irq_any <= 1'b1;
    repeat (5) @(posedge pclk);
    check(32'(mode_out_q), 32'(pmc_pkg::PMC_SLEEP), "frozen");
    ce <= 1'b1;
    @(posedge pclk);
    irq_any <= 1'b0;
    wait_mode(pmc_pkg::PMC_MAIN_ACTIVE);
    apb(1'b0, pmc_pkg::ADDR_SLEEP, 32'h0);
    check(rd, 32'h0, "sleep cleared");
    // Stop, released by each wake source in turn.
    apb(1'b1, pmc_pkg::ADDR_CLOCK_MODE, 32'h0000_0008);
    for (int k = 0; k < 5; k++) begin
      @(posedge pclk);
      event_counter_mode <= k[0];
      enter_stop();
      count_pulses(100);
      check(32'(ns + np), 32'h0, "clocks halted");
      check(32'(main_osc_en_q), 32'h0, "main halted");
      check(32'(sub_osc_en_q), 32'h1, "sub runs");
      check(32'(hold_state_q), 32'h1, "state held");
      check(32'(bit_halt_q), 32'h1, "interval halt");
      check(32'(tc_halt_q), 32'(!k[0]), "timer halt");
      @(posedge pclk);
      irq_any <= 1'b1;
      @(posedge pclk);
      irq_any <= 1'b0;
      repeat (5) @(posedge pclk);
      check(32'(mode_out_q), 32'(pmc_pkg::PMC_STOP), "no irq exit");
      wake <= pmc_pkg::pmc_wake_type'(5'h01 << k);
      wait_mode(pmc_pkg::PMC_MAIN_ACTIVE);
      wake <= '0;
      apb(1'b0, pmc_pkg::ADDR_CLOCK_MODE, 32'h0);
      check(rd, 32'h0000_0008, "register kept");
      check(32'(cpu_div_sel_q), 32'h2, "divider kept");
    end
    enter_stop();
    pulse_reset();
    wait_mode(pmc_pkg::PMC_MAIN_ACTIVE);
    apb(1'b0, pmc_pkg::ADDR_CLOCK_MODE, 32'h0);
    check(rd, 32'h0, "reset redefines");
    report_and_stop();
  end
endmodule // pmc_mode_ctrl_test
`default_nettype wire
